// ===== shared/irqsp_pkg.sv
// ----------------------------------------
// register map and field layout
// ----------------------------------------
package irqsp_pkg;
	localparam int NUM_PINS = 8; // external request pins
	localparam int NUM_PRIO = 10; // priority registers
	localparam int PRIO_W = 4; // width of one priority field
	// byte offsets of the word-aligned registers
	localparam logic [7:0] OFS_STATUS = 8'h00; // request flags, pin 0 at bit 7
	localparam logic [7:0] OFS_PRIO_A = 8'h04; // first of ten priority words
	localparam logic [7:0] OFS_SENSE = 8'h2C; // sense select, bit n = pin n
	localparam logic [7:0] OFS_EDGE = 8'h30; // edge select, pin 0 at bits 15:14
	localparam logic [7:0] OFS_EVENT = 8'h34; // sticky event bits, write one to clear
	localparam logic [7:0] OFS_MASK = 8'h38; // event mask, one enables
	localparam logic [7:0] OFS_LAST = 8'h38; // highest mapped offset
	// field layout
	localparam int FLAG_MSB = 7; // request flags occupy 7:0
	localparam int STATUS_W = 16; // status register width
	localparam int PRIO_REG_W = 16; // priority register width
	// reset values
	localparam logic [15:0] RST_PRIO = 16'h0000;
	localparam logic [7:0] RST_FLAGS = 8'h00;
	localparam logic [7:0] RST_SENSE = 8'h00;
	localparam logic [15:0] RST_EDGE = 16'h0000;
	localparam logic [7:0] RST_MASK = 8'h00;
	// sense select encodings
	localparam logic SENSE_LOW = 1'b0; // low level detection
	localparam logic SENSE_EDGE = 1'b1; // edge detection
	// edge select encodings
	localparam logic [1:0] EDGE_FALL = 2'h0;
	localparam logic [1:0] EDGE_RISE = 2'h1;
	localparam logic [1:0] EDGE_BOTH = 2'h2;
	localparam logic [1:0] EDGE_BAD = 2'h3; // not allowed, detects nothing
	localparam logic [3:0] PRIO_MASKED = 4'h0; // level zero masks the pin request, not IRQ_OUT
endpackage : irqsp_pkg

// ===== rtl/irqsp_regs.sv
// Overview of operation
// - 16-bit status register shows eight pin requests
// - status bits 15:8 always read zero
// - bit 7 is pin 0, bit 0 pin 7
// - flag sets on selected level or edge
// - write zero after reading one clears flag
// - low mode: exception clears flag if pin high
// - edge modes: exception clears held flag
// - transfer start clears flag if post-select zero
// - ten 16-bit priority registers, reset zero
// - priorities cover all but non-maskable source
// - four 4-bit priority fields per register
// - field value zero lowest, fifteen highest
// - edge select: 00 fall, 01 rise, 10 both
// - low mode requests only while pin low
// - priority zero masks the pin request, not IRQ_OUT
`timescale 1ns/100ps
`default_nettype none
module irqsp_regs #(
	parameter int NPINS = irqsp_pkg::NUM_PINS
) (
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic [7:0] IRQ_PIN_N,
	input wire logic EXC_ACCEPT,
	input wire logic [2:0] EXC_PIN,
	input wire logic XFER_START,
	input wire logic [2:0] XFER_PIN,
	input wire logic POST_TRANSFER_INT_SELECT,
	output logic [7:0] PIN_REQUEST,
	output logic [31:0] PRIO_LEVELS,
	output logic IRQ_OUT
);
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	// bit order of the status register is reversed against pin number
	function automatic logic [7:0] rev8(input logic [7:0] v);
		logic [7:0] r;
		r = 8'h00;
		for (int i = 0; i < 8; i++) begin
			r[i] = v[7 - i];
		end
		return r;
	endfunction : rev8

	// ----------------------------------------
	// state
	// ----------------------------------------
	logic [15:0] prio [irqsp_pkg::NUM_PRIO]; // priority words
	logic [15:0] next_prio [irqsp_pkg::NUM_PRIO];
	logic [7:0] sense, next_sense; // sense select
	logic [15:0] edge_sel, next_edge_sel; // edge select
	logic [7:0] flag, next_flag; // request flags, index = pin
	logic [7:0] armed, next_armed; // flags seen as one by a read
	logic [7:0] evt, next_evt; // sticky events
	logic [7:0] mask, next_mask;
	logic [7:0] sync1, sync2, sync3; // pin synchroniser and history
	logic [31:0] next_prdata;
	logic next_pready, next_pslverr, next_irq;
	logic [7:0] next_req;
	logic [31:0] next_levels;
	logic [7:0] set, clr; // per-pin set and clear terms
	logic [7:0] pin_low; // synchronised pin level, active low input
	logic [7:0] exc_hit, xfer_hit; // decoded pin of each clearing event
	logic [3:0] lvl [8]; // priority field of each pin

	// access completes on the edge where PREADY is seen high
	logic done, wr_done, rd_done, mapped;
	logic [3:0] idx;
	assign done = PSEL & PENABLE & PREADY;
	assign wr_done = done & PWRITE & ~PSLVERR;
	assign rd_done = done & ~PWRITE & ~PSLVERR;
	assign idx = PADDR[5:2];
	assign mapped = (PADDR[1:0] == 2'h0) && (PADDR <= irqsp_pkg::OFS_LAST);

	// ----------------------------------------
	// pin synchroniser
	// ----------------------------------------
	// pins are asynchronous; sync1 is read only by sync2
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			sync1 <= 8'hFF;
			sync2 <= 8'hFF;
			sync3 <= 8'hFF;
		end else begin
			sync1 <= IRQ_PIN_N;
			sync2 <= sync1;
			sync3 <= sync2;
		end
	end
	assign pin_low = ~sync2;

	// ----------------------------------------
	// detection and clearing
	// ----------------------------------------
	// pin n uses field 15-4(n mod 4) of word a (pins 0-3) or word b (pins 4-7)
	always_comb begin
		for (int n = 0; n < 8; n++) begin
			lvl[n] = prio[n / 4][15 - 4 * (n % 4) -: 4];
		end
	end

	always_comb begin
		set = 8'h00;
		clr = 8'h00;
		exc_hit = 8'h00;
		xfer_hit = 8'h00;
		exc_hit[EXC_PIN] = EXC_ACCEPT;
		xfer_hit[XFER_PIN] = XFER_START;
		for (int n = 0; n < NPINS; n++) begin
			if (sense[n] == irqsp_pkg::SENSE_LOW) begin
				set[n] = pin_low[n];
				clr[n] = exc_hit[n] & ~pin_low[n];
			end else begin
				unique case (edge_sel[15 - 2 * n -: 2])
					irqsp_pkg::EDGE_FALL: set[n] = sync3[n] & ~sync2[n];
					irqsp_pkg::EDGE_RISE: set[n] = ~sync3[n] & sync2[n];
					irqsp_pkg::EDGE_BOTH: set[n] = sync3[n] ^ sync2[n];
					default: set[n] = 1'b0; // forbidden code detects nothing
				endcase
				clr[n] = exc_hit[n];
			end
			// transfer controller consumes the request
			// a transfer that keeps its interrupt leaves the flag for the handler
			if (xfer_hit[n] && !POST_TRANSFER_INT_SELECT) begin
				clr[n] = 1'b1;
			end
		end
		// a zero written to an armed flag clears it
		if (wr_done && PADDR == irqsp_pkg::OFS_STATUS) begin
			clr = clr | (armed & ~rev8(PWDATA[7:0]));
		end
	end

	// ----------------------------------------
	// flags, arming and events
	// ----------------------------------------
	always_comb begin
		// set wins over every clear
		next_flag = set | (flag & ~clr);
		next_armed = armed & flag;
		if (wr_done && PADDR == irqsp_pkg::OFS_STATUS) begin
			next_armed = 8'h00;
		end else if (rd_done && PADDR == irqsp_pkg::OFS_STATUS) begin
			// arm exactly the ones the master was handed
			next_armed = armed | (rev8(PRDATA[7:0]) & flag);
		end
		next_evt = evt;
		if (wr_done && PADDR == irqsp_pkg::OFS_EVENT) begin
			next_evt = evt & ~PWDATA[7:0];
		end
		next_evt = next_evt | (set & ~flag);
		next_irq = |(next_evt & mask);
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			flag <= irqsp_pkg::RST_FLAGS;
			armed <= 8'h00;
			evt <= 8'h00;
			IRQ_OUT <= 1'b0;
		end else begin
			flag <= next_flag;
			armed <= next_armed;
			evt <= next_evt;
			IRQ_OUT <= next_irq;
		end
	end

	// ----------------------------------------
	// requests to the interrupt core
	// ----------------------------------------
	always_comb begin
		next_req = 8'h00;
		for (int n = 0; n < NPINS; n++) begin
			if (lvl[n] != irqsp_pkg::PRIO_MASKED) begin
				// low mode follows the pin, not the held flag
				next_req[n] = (sense[n] == irqsp_pkg::SENSE_LOW) ? pin_low[n] : flag[n];
			end
		end
		next_levels = {prio[1], prio[0]};
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			PIN_REQUEST <= 8'h00;
			PRIO_LEVELS <= 32'h0000_0000;
		end else begin
			PIN_REQUEST <= next_req;
			PRIO_LEVELS <= next_levels;
		end
	end

	// ----------------------------------------
	// configuration registers
	// ----------------------------------------
	// the non-maskable source has no field here
	always_comb begin
		next_prio = prio;
		next_sense = sense;
		next_edge_sel = edge_sel;
		next_mask = mask;
		if (wr_done) begin
			if (idx >= 4'h1 && idx <= 4'hA) begin
				next_prio[idx - 4'h1] = PWDATA[15:0];
			end
			unique case (PADDR)
				irqsp_pkg::OFS_SENSE: next_sense = PWDATA[7:0];
				irqsp_pkg::OFS_EDGE: next_edge_sel = PWDATA[15:0];
				irqsp_pkg::OFS_MASK: next_mask = PWDATA[7:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			for (int i = 0; i < irqsp_pkg::NUM_PRIO; i++) begin
				prio[i] <= irqsp_pkg::RST_PRIO;
			end
			sense <= irqsp_pkg::RST_SENSE;
			edge_sel <= irqsp_pkg::RST_EDGE;
			mask <= irqsp_pkg::RST_MASK;
		end else begin
			prio <= next_prio;
			sense <= next_sense;
			edge_sel <= next_edge_sel;
			mask <= next_mask;
		end
	end

	// ----------------------------------------
	// bus slave
	// ----------------------------------------
	// one wait-free access phase; read data is captured in the setup
	// cycle, so a flag set during the access shows on the next read
	always_comb begin
		next_pready = PSEL & ~PENABLE;
		next_pslverr = PSEL & ~PENABLE & ~mapped;
		next_prdata = 32'h0000_0000;
		if (PSEL && !PENABLE && !PWRITE && mapped) begin
			if (idx >= 4'h1 && idx <= 4'hA) begin
				next_prdata[15:0] = prio[idx - 4'h1];
			end
			unique case (PADDR)
				// upper byte stays zero whatever was written
				irqsp_pkg::OFS_STATUS: next_prdata[7:0] = rev8(flag);
				irqsp_pkg::OFS_SENSE: next_prdata[7:0] = sense;
				irqsp_pkg::OFS_EDGE: next_prdata[15:0] = edge_sel;
				irqsp_pkg::OFS_EVENT: next_prdata[7:0] = evt;
				irqsp_pkg::OFS_MASK: next_prdata[7:0] = mask;
				default: ;
			endcase
		end
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			PRDATA <= 32'h0000_0000;
			PREADY <= 1'b0;
			PSLVERR <= 1'b0;
		end else begin
			PRDATA <= next_prdata;
			PREADY <= next_pready;
			PSLVERR <= next_pslverr;
		end
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	sequence s_status_setup;
		PSEL && !PENABLE && !PWRITE && PADDR == irqsp_pkg::OFS_STATUS;
	endsequence

	sequence s_status_zero_write;
		wr_done && PADDR == irqsp_pkg::OFS_STATUS && PWDATA[7] == 1'b0;
	endsequence

	property p_reserved_zero;
		@(posedge CLK) disable iff (!RST_N)
		s_status_setup |=> PREADY && PRDATA[31:8] == 24'h0;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("status upper bits not zero");

	property p_reversed_order;
		@(posedge CLK) disable iff (!RST_N)
		s_status_setup |=> PRDATA[7] == $past(flag[0]) && PRDATA[0] == $past(flag[7]);
	endproperty
	a_reversed_order: assert property (p_reversed_order) else $error("flag order wrong");

	property p_fall_sets;
		@(posedge CLK) disable iff (!RST_N)
		sense[0] && edge_sel[15:14] == irqsp_pkg::EDGE_FALL && sync3[0] && !sync2[0]
			|=> flag[0];
	endproperty
	a_fall_sets: assert property (p_fall_sets) else $error("falling edge missed");

	property p_armed_clear;
		@(posedge CLK) disable iff (!RST_N)
		s_status_zero_write and armed[0] && !set[0] |=> !flag[0];
	endproperty
	a_armed_clear: assert property (p_armed_clear) else $error("armed flag kept");

	// pin 1 is the flag that rises after the read, so it meets the write unarmed
	property p_unarmed_kept;
		@(posedge CLK) disable iff (!RST_N)
		wr_done && PADDR == irqsp_pkg::OFS_STATUS && PWDATA[6] == 1'b0
			&& flag[1] && !armed[1] && !EXC_ACCEPT && !XFER_START
			|=> flag[1] ##1 !armed[1];
	endproperty
	a_unarmed_kept: assert property (p_unarmed_kept) else $error("unarmed flag cleared");

	property p_low_exc;
		@(posedge CLK) disable iff (!RST_N)
		!sense[3] && EXC_ACCEPT && EXC_PIN == 3'h3 && sync2[3] |=> !flag[3];
	endproperty
	a_low_exc: assert property (p_low_exc) else $error("low mode exception clear");

	property p_edge_exc;
		@(posedge CLK) disable iff (!RST_N)
		sense[3] && EXC_ACCEPT && EXC_PIN == 3'h3 && !set[3] |=> !flag[3];
	endproperty
	a_edge_exc: assert property (p_edge_exc) else $error("edge mode exception clear");

	property p_xfer_clear;
		@(posedge CLK) disable iff (!RST_N)
		XFER_START && XFER_PIN == 3'h4 && !POST_TRANSFER_INT_SELECT && !set[4] |=> !flag[4];
	endproperty
	a_xfer_clear: assert property (p_xfer_clear) else $error("transfer start clear");

	property p_level_request;
		@(posedge CLK) disable iff (!RST_N)
		!sense[3] && lvl[3] != 4'h0 && $stable(lvl[3]) && $stable(sense[3])
			|=> PIN_REQUEST[3] == $past(pin_low[3]);
	endproperty
	a_level_request: assert property (p_level_request) else $error("level request wrong");

	property p_zero_masks;
		@(posedge CLK) disable iff (!RST_N)
		(lvl[3] == irqsp_pkg::PRIO_MASKED) [*2] |-> !PIN_REQUEST[3];
	endproperty
	a_zero_masks: assert property (p_zero_masks) else $error("masked source requested");

	property p_prio_write;
		@(posedge CLK) disable iff (!RST_N)
		wr_done && PADDR == irqsp_pkg::OFS_PRIO_A |=> prio[0] == $past(PWDATA[15:0]);
	endproperty
	a_prio_write: assert property (p_prio_write) else $error("priority write lost");

	// edge modes: the request is the held flag, so any clear withdraws it
	property p_edge_request;
		@(posedge CLK) disable iff (!RST_N)
		sense[4] && lvl[4] != irqsp_pkg::PRIO_MASKED |=> PIN_REQUEST[4] == $past(flag[4]);
	endproperty
	a_edge_request: assert property (p_edge_request) else $error("edge request not the flag");

	// a fresh unmasked event raises the interrupt in the cycle it is stored
	property p_event_irq;
		@(posedge CLK) disable iff (!RST_N)
		$rose(evt[6]) && mask[6] && $stable(mask) |-> IRQ_OUT;
	endproperty
	a_event_irq: assert property (p_event_irq) else $error("event did not interrupt");
endmodule : irqsp_regs
`default_nettype wire

// ===== test/irqsp_pins.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// pin and exception side model
// ----------------------------------------
module irqsp_pins (
	input wire logic clk,
	output logic [7:0] pin_n,
	output logic exc_accept,
	output logic [2:0] exc_pin,
	output logic xfer_start,
	output logic [2:0] xfer_pin,
	output logic post_sel
);
	// pins idle high behind pull-ups
	initial begin
		pin_n = 8'hFF;
		exc_accept = 1'b0;
		exc_pin = 3'h0;
		xfer_start = 1'b0;
		xfer_pin = 3'h0;
		post_sel = 1'b0;
	end
	// move one pin just after an edge
	task automatic drive(input int n, input logic v);
		@(posedge clk);
		pin_n[n] <= v;
	endtask : drive
	// one-cycle acceptance pulse for a pin
	task automatic exc(input logic [2:0] n);
		@(posedge clk);
		exc_accept <= 1'b1;
		exc_pin <= n;
		@(posedge clk);
		exc_accept <= 1'b0;
	endtask : exc
	// transfer start; sel one keeps the flag
	task automatic xfer(input logic [2:0] n, input logic sel);
		@(posedge clk);
		xfer_start <= 1'b1;
		xfer_pin <= n;
		post_sel <= sel;
		@(posedge clk);
		xfer_start <= 1'b0;
	endtask : xfer
endmodule : irqsp_pins
`default_nettype wire

// ===== test/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
	// ----------------------------------------
	// wiring
	// ----------------------------------------
	localparam logic [7:0] a_st = irqsp_pkg::OFS_STATUS;
	localparam logic [7:0] a_se = irqsp_pkg::OFS_SENSE;
	localparam logic [7:0] a_ed = irqsp_pkg::OFS_EDGE;
	localparam logic [7:0] a_ev = irqsp_pkg::OFS_EVENT;
	localparam logic [7:0] a_mk = irqsp_pkg::OFS_MASK;
	logic clk, rst_n, psel, penable, pwrite, pready, pslverr, irq_out, err;
	logic exc_accept, xfer_start, post_sel;
	logic [2:0] exc_pin, xfer_pin;
	logic [7:0] paddr, pin_n, pin_req;
	logic [31:0] pwdata, prdata, prio, rd;
	int fail_count = 0;
	int n_checks = 0;
	irqsp_regs dut (.CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
		.PREADY(pready), .PSLVERR(pslverr), .IRQ_PIN_N(pin_n),
		.EXC_ACCEPT(exc_accept), .EXC_PIN(exc_pin), .XFER_START(xfer_start),
		.XFER_PIN(xfer_pin), .POST_TRANSFER_INT_SELECT(post_sel),
		.PIN_REQUEST(pin_req), .PRIO_LEVELS(prio), .IRQ_OUT(irq_out));
	irqsp_pins pins (.clk(clk), .pin_n(pin_n), .exc_accept(exc_accept),
		.exc_pin(exc_pin), .xfer_start(xfer_start), .xfer_pin(xfer_pin),
		.post_sel(post_sel));
	// 25 ns period
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask : cyc
	// one transfer; waits on pready, never on a fixed count
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		rd = prdata;
		err = pslverr;
		if (k >= 20) fail_count++;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wrap_up();
		$display("checks=%0d failures=%0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : wrap_up
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_regs();
		for (int i = 0; i < 11; i++) begin
			apb(1'b0, 8'(4 * i), 32'h0);
			chk(rd, 32'h0);
		end
		// upper half written ones; must not stick
		for (int i = 0; i < 10; i++)
			apb(1'b1, 8'(4 + 4 * i), {16'hFFFF, 16'(16'h1111 * (i + 1))});
		for (int i = 0; i < 10; i++) begin
			apb(1'b0, 8'(4 + 4 * i), 32'h0);
			chk(rd, {16'h0, 16'(16'h1111 * (i + 1))});
		end
		chk(prio, 32'h2222_1111);
		apb(1'b0, 8'h3C, 32'h0);
		chk({rd[30:0], err}, 32'h1);
	endtask : t_regs
	// read arms, a flag set after the read survives the zero write
	task automatic t_fall();
		apb(1'b1, a_se, 32'hFF);
		apb(1'b1, a_ed, 32'h0);
		pins.drive(0, 1'b0);
		cyc(5);
		apb(1'b0, a_st, 32'h0);
		chk(rd, 32'h80);
		pins.drive(1, 1'b0);
		cyc(5);
		apb(1'b1, a_st, 32'h0);
		apb(1'b0, a_st, 32'h0);
		chk(rd, 32'h40);
		apb(1'b1, a_st, 32'h0);
		apb(1'b0, a_st, 32'h0);
		chk(rd, 32'h0);
	endtask : t_fall
	// every edge code on pin 2, both directions
	task automatic t_modes();
		for (int m = 0; m < 4; m++) begin
			apb(1'b1, a_ed, 32'(m) << 10);
			for (int v = 0; v < 2; v++) begin
				pins.drive(2, v[0]);
				cyc(5);
				apb(1'b0, a_st, 32'h0);
				chk(rd, (m == 2 || m == v) ? 32'h20 : 32'h0);
				apb(1'b1, a_st, 32'h0);
			end
		end
	endtask : t_modes
	task automatic t_clears();
		apb(1'b1, a_ed, 32'h0);
		pins.drive(3, 1'b0);
		pins.drive(4, 1'b0);
		cyc(5);
		pins.exc(3'h3);
		pins.xfer(3'h4, 1'b1);
		cyc(2);
		chk(32'(pin_req), 32'h10);
		apb(1'b0, a_st, 32'h0);
		chk(rd, 32'h08);
		pins.xfer(3'h4, 1'b0);
		cyc(2);
		apb(1'b0, a_st, 32'h0);
		chk(rd, 32'h0);
		pins.drive(3, 1'b1);
	endtask : t_clears
	// pin 3 in level mode
	task automatic t_low();
		apb(1'b1, a_se, 32'hF7);
		pins.drive(3, 1'b0);
		cyc(5);
		chk(32'(pin_req[3]), 32'h1);
		pins.exc(3'h3);
		cyc(2);
		apb(1'b0, a_st, 32'h0);
		chk(rd, 32'h10);
		pins.drive(3, 1'b1);
		cyc(5);
		chk(32'(pin_req[3]), 32'h0);
		pins.exc(3'h3);
		cyc(2);
		apb(1'b0, a_st, 32'h0);
		chk(rd, 32'h0);
		apb(1'b1, 8'h04, 32'h1110);
		pins.drive(3, 1'b0);
		cyc(5);
		chk(32'(pin_req[3]), 32'h0);
		pins.drive(3, 1'b1);
	endtask : t_low
	task automatic t_irq();
		apb(1'b1, a_ev, 32'hFF);
		apb(1'b1, a_mk, 32'h40);
		apb(1'b0, a_mk, 32'h0);
		chk(rd, 32'h40);
		pins.drive(6, 1'b0);
		cyc(5);
		chk(32'(irq_out), 32'h1);
		apb(1'b1, a_mk, 32'h0);
		cyc(2);
		chk(32'(irq_out), 32'h0);
		apb(1'b1, a_mk, 32'h40);
		apb(1'b1, a_ev, 32'h40);
		cyc(2);
		chk(32'(irq_out), 32'h0);
		apb(1'b0, a_ev, 32'h0);
		chk(rd, 32'h0);
	endtask : t_irq
	// ----------------------------------------
	// main sequence and watchdog
	// ----------------------------------------
	initial begin
		rst_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		t_regs();
		t_fall();
		t_modes();
		t_clears();
		t_low();
		t_irq();
		wrap_up();
	end
	// whole run is well under two thousand cycles
	initial begin
		repeat (20000) @(posedge clk);
		fail_count++;
		wrap_up();
	end
endmodule : testbench
`default_nettype wire
